//--- design/dtc_consts.svh
// Purpose: offsets, field positions, reset values and divider counts of the timer pair
// Assumes: 8-bit special-function register space
// Notes:   definitions only
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// register offsets
`define DTC_ADDR_RUN_FLAG   8'h88
`define DTC_ADDR_MODE       8'h89
`define DTC_ADDR_TMR0_LO    8'h8a
`define DTC_ADDR_TMR1_LO    8'h8b
`define DTC_ADDR_TMR0_HI    8'h8c
`define DTC_ADDR_TMR1_HI    8'h8d
`define DTC_ADDR_CLK_CTRL   8'h8e

// reset values
`define DTC_RST_RUN_FLAG    8'h00
`define DTC_RST_MODE        8'h00
`define DTC_RST_CLK_CTRL    8'h00
`define DTC_RST_COUNT       8'h00

// clock control fields
`define DTC_CK_T3_HI        7
`define DTC_CK_T3_LO        6
`define DTC_CK_T2_HI        5
`define DTC_CK_T2_LO        4
`define DTC_CK_TMR1_SYS     3
`define DTC_CK_TMR0_SYS     2
`define DTC_CK_DIV_HI       1
`define DTC_CK_DIV_LO       0

// run and flag fields
`define DTC_RF_FLAG1        7
`define DTC_RF_RUN1         6
`define DTC_RF_FLAG0        5
`define DTC_RF_RUN0         4

// mode register fields
`define DTC_MD_TIMER1_GATED        7
`define DTC_MD_EVT1         6
`define DTC_MD_M1_HI        5
`define DTC_MD_M1_LO        4
`define DTC_MD_TIMER0_GATED        3
`define DTC_MD_EVT0         2
`define DTC_MD_M0_HI        1
`define DTC_MD_M0_LO        0

// mode encodings
`define DTC_MODE_13BIT      2'h0
`define DTC_MODE_16BIT      2'h1
`define DTC_MODE_RELOAD     2'h2
`define DTC_MODE_SPLIT      2'h3

// shared divider selections and counts
`define DTC_SCALE_12        2'h0
`define DTC_SCALE_4         2'h1
`define DTC_SCALE_48        2'h2
`define DTC_SCALE_EXT       2'h3
`define DTC_DIV_12          6'h0c
`define DTC_DIV_4           6'h04
`define DTC_DIV_48          6'h30
`define DTC_DIV_EXT         6'h08

`endif

//--- design/dtc_pkg.sv
// Purpose: types shared by the timer pair
// Assumes: nothing
// Notes:   offsets and counts live in dtc_consts.svh
package dtc_pkg;

   // special-function register access
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dtc_sfr_req_t;

   // one timer's byte pair and its overflow
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic       ovf;
   } dtc_cnt_t;

endpackage

//--- design/dtc_edge_sync.sv
// Purpose: two-flop synchroniser with edge detection for one pin
// Assumes: pin may change at any time
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module dtc_edge_sync
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // pin
   input  wire logic pin,
   // synchronised view
   output logic      level,
   output logic      fall,
   output logic      rise
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;

   always_comb
   begin
      sync_next = {sync_reg[1:0], pin};
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         sync_reg <= 3'h0;
      else
         sync_reg <= sync_next;
   end

   assign level = sync_reg[1];
   assign fall  = sync_reg[2] & ~sync_reg[1];
   assign rise  = ~sync_reg[2] & sync_reg[1];
endmodule
`default_nettype wire

//--- design/dtc_prescaler.sv
// Purpose: shared divider for both timers
// Assumes: ext_rise is already synchronised
// Notes:   tick is one system clock wide
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_prescaler
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // selection
   input  wire logic [1:0] sel,
   input  wire logic       ext_rise,
   // output
   output logic            tick
);
   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic [5:0] limit;
   logic       step;

   always_comb
   begin
      case (sel)
         `DTC_SCALE_12: limit = `DTC_DIV_12;
         `DTC_SCALE_4:  limit = `DTC_DIV_4;
         `DTC_SCALE_48: limit = `DTC_DIV_48;
         default:       limit = `DTC_DIV_EXT;
      endcase
      step     = (sel == `DTC_SCALE_EXT) ? ext_rise : 1'b1;
      tick     = step && (cnt_reg >= limit - 6'h1);
      cnt_next = cnt_reg;
      if (tick)
         cnt_next = 6'h0;
      else if (step)
         cnt_next = cnt_reg + 6'h1;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         cnt_reg <= 6'h0;
      else
         cnt_reg <= cnt_next;
   end
endmodule
`default_nettype wire

//--- design/dtc_timer_pair.sv
// Purpose: two 8051-style counter/timers with clock control and prescaler
// Assumes: single-cycle register bus, read data one clock after rd
// Notes:   timers 2 and 3 only get their clock-select bits from here
//
// Overview of operation
// - clock control bits 7 and 6 choose system clock for timer 3 bytes.
// - clock control bits 5 and 4 choose system clock for timer 2 bytes.
// - bit 3 picks timer 1 system clock or prescaler; ignored when counting events.
// - bit 2 picks timer 0 system clock or prescaler; ignored when counting events.
// - divider field gives clock over 12, 4, 48 or external clock over 8.
// - each timer holds a 16-bit count read and written as two bytes.
// - each timer has its own independent two-bit mode field.
// - mode 0 is 13 bits: high byte plus low five bits of low byte.
// - 13-bit wrap from 0x1fff to zero sets the overflow flag.
// - event select counts falling pin edges, otherwise the selected clock.
// - counting needs run bit and either gate off or gate input active.
// - setting run never clears the count; software preloads it first.
// - timer 1 mirrors timer 0 with its own bits and second gate input.
// - mode 1 uses all 16 bits, gated and clocked as in mode 0.
// - mode 2 low byte wraps, sets flag, reloads from unchanged high byte.
// - mode 3 timer 0 low byte is an 8-bit counter on timer 0 controls.
// - mode 3 timer 0 high byte uses internal clock, timer 1 run and flag.
// - with timer 0 split, timer 1 uses internal clocks, never sets flag.
// - timer 1 mode 3 halts it; with timer 0 split, modes 0-2 run.
// - mode codes 00 13-bit, 01 16-bit, 10 reload, 11 split or inactive.
// - overflow flag cleared by software write or by interrupt vectoring.
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_timer_pair
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // register access
   input  wire dtc_pkg::dtc_sfr_req_t sfr_req,
   output logic [7:0]                sfr_rdata,
   // pins
   input  wire logic                 event_pin_a,
   input  wire logic                 event_pin_b,
   input  wire logic                 gate_input_a,
   input  wire logic                 gate_input_b,
   input  wire logic                 ext_clock_in,
   // interrupt controller side
   input  wire logic                 gate_a_polarity,
   input  wire logic                 gate_b_polarity,
   input  wire logic                 timer0_irq_enable,
   input  wire logic                 timer1_irq_enable,
   input  wire logic                 timer0_vector_ack,
   input  wire logic                 timer1_vector_ack,
   // results
   output logic                      timer0_irq,
   output logic                      timer1_irq,
   output logic                      timer0_overflow_pulse,
   output logic                      timer1_overflow_pulse,
   output logic [7:0]                timer_clock_control
);
   import dtc_pkg::*;

   // one count step for the given mode; split mode steps the low byte alone
   function automatic dtc_cnt_t step_count(input logic [1:0] mode, input dtc_cnt_t cur);
      logic [13:0] v13;
      logic [16:0] v16;
      logic [8:0]  v8;
      dtc_cnt_t    res;
      v13 = {1'b0, cur.hi, cur.lo[4:0]} + 14'h1;
      v16 = {1'b0, cur.hi, cur.lo} + 17'h1;
      v8  = {1'b0, cur.lo} + 9'h1;
      res = cur;
      res.ovf = 1'b0;
      case (mode)
         `DTC_MODE_13BIT:
         begin
            res.hi  = v13[12:5];
            res.lo  = {cur.lo[7:5], v13[4:0]};
            res.ovf = v13[13];
         end
         `DTC_MODE_16BIT:
         begin
            res.hi  = v16[15:8];
            res.lo  = v16[7:0];
            res.ovf = v16[16];
         end
         `DTC_MODE_RELOAD:
         begin
            res.lo  = v8[8] ? cur.hi : v8[7:0];
            res.ovf = v8[8];
         end
         default:
         begin
            res.lo  = v8[7:0];
            res.ovf = v8[8];
         end
      endcase
      return res;
   endfunction

   // gate active when level matches polarity
   function automatic logic gate_ok(input logic gated, input logic lvl, input logic pol);
      return ~gated | (lvl == pol);
   endfunction

   // register state
   logic [7:0] clk_ctrl_reg;
   logic [7:0] clk_ctrl_next;
   logic [7:0] mode_reg;
   logic [7:0] mode_next;
   logic       run0_reg;
   logic       run0_next;
   logic       run1_reg;
   logic       run1_next;
   logic       flag0_reg;
   logic       flag0_next;
   logic       flag1_reg;
   logic       flag1_next;
   logic [7:0] t0_lo_reg;
   logic [7:0] t0_lo_next;
   logic [7:0] t0_hi_reg;
   logic [7:0] t0_hi_next;
   logic [7:0] t1_lo_reg;
   logic [7:0] t1_lo_next;
   logic [7:0] t1_hi_reg;
   logic [7:0] t1_hi_next;
   logic       ovf0_reg;
   logic       ovf0_next;
   logic       ovf1_reg;
   logic       ovf1_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // synchronised pins
   logic       evt_a_fall;
   logic       evt_b_fall;
   logic       gate_a_lvl;
   logic       gate_b_lvl;
   logic       ext_rise;
   logic       presc_tick;

   // derived controls
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic       t0_split;
   logic       gate_input_a_tick;
   logic       gate_input_b_tick;
   logic       t0_tick;
   logic       t1_tick;
   logic       t0_en;
   logic       t1_en;
   logic       hi0_en;
   logic       hi0_ovf;
   logic [8:0] hi0_sum;
   dtc_cnt_t   c0;
   dtc_cnt_t   c1;
   dtc_cnt_t   s0;
   dtc_cnt_t   s1;
   logic       wr_hit;

   dtc_edge_sync u_sync_evt_a
   (
      .clock (clock),
      .rst   (rst),
      .pin   (event_pin_a),
      .level (),
      .fall  (evt_a_fall),
      .rise  ()
   );

   dtc_edge_sync u_sync_evt_b
   (
      .clock (clock),
      .rst   (rst),
      .pin   (event_pin_b),
      .level (),
      .fall  (evt_b_fall),
      .rise  ()
   );

   dtc_edge_sync u_sync_gate_a
   (
      .clock (clock),
      .rst   (rst),
      .pin   (gate_input_a),
      .level (gate_a_lvl),
      .fall  (),
      .rise  ()
   );

   dtc_edge_sync u_sync_gate_b
   (
      .clock (clock),
      .rst   (rst),
      .pin   (gate_input_b),
      .level (gate_b_lvl),
      .fall  (),
      .rise  ()
   );

   dtc_edge_sync u_sync_ext_clk
   (
      .clock (clock),
      .rst   (rst),
      .pin   (ext_clock_in),
      .level (),
      .fall  (),
      .rise  (ext_rise)
   );

   dtc_prescaler u_prescaler
   (
      .clock    (clock),
      .rst      (rst),
      .sel      (clk_ctrl_reg[`DTC_CK_DIV_HI:`DTC_CK_DIV_LO]),
      .ext_rise (ext_rise),
      .tick     (presc_tick)
   );

   // clock and enable selection
   always_comb
   begin
      mode0     = mode_reg[`DTC_MD_M0_HI:`DTC_MD_M0_LO];
      mode1     = mode_reg[`DTC_MD_M1_HI:`DTC_MD_M1_LO];
      t0_split  = (mode0 == `DTC_MODE_SPLIT);
      gate_input_a_tick = clk_ctrl_reg[`DTC_CK_TMR0_SYS] | presc_tick;
      gate_input_b_tick = clk_ctrl_reg[`DTC_CK_TMR1_SYS] | presc_tick;
      t0_tick   = mode_reg[`DTC_MD_EVT0] ? evt_a_fall : gate_input_a_tick;
      t1_tick   = (mode_reg[`DTC_MD_EVT1] && !t0_split) ? evt_b_fall : gate_input_b_tick;
      t0_en     = run0_reg && gate_ok(mode_reg[`DTC_MD_TIMER0_GATED], gate_a_lvl, gate_a_polarity);
      if (mode1 == `DTC_MODE_SPLIT)
         t1_en = 1'b0;
      else if (t0_split)
         t1_en = 1'b1;
      else
         t1_en = run1_reg && gate_ok(mode_reg[`DTC_MD_TIMER1_GATED], gate_b_lvl, gate_b_polarity);
      hi0_en    = t0_split && run1_reg && gate_input_a_tick;
      hi0_sum   = {1'b0, t0_hi_reg} + 9'h1;
      hi0_ovf   = hi0_en && hi0_sum[8];
   end

   // counting and register writes
   always_comb
   begin
      c0 = '{hi: t0_hi_reg, lo: t0_lo_reg, ovf: 1'b0};
      c1 = '{hi: t1_hi_reg, lo: t1_lo_reg, ovf: 1'b0};
      s0 = c0;
      s1 = c1;
      if (t0_en && t0_tick)
         s0 = step_count(mode0, c0);
      if (t1_en && t1_tick)
         s1 = step_count(mode1, c1);
      if (hi0_en)
         s0.hi = hi0_sum[7:0];
      wr_hit        = sfr_req.wr;
      t0_lo_next    = s0.lo;
      t0_hi_next    = s0.hi;
      t1_lo_next    = s1.lo;
      t1_hi_next    = s1.hi;
      clk_ctrl_next = clk_ctrl_reg;
      mode_next     = mode_reg;
      run0_next     = run0_reg;
      run1_next     = run1_reg;
      flag0_next    = flag0_reg;
      flag1_next    = flag1_reg;
      if (wr_hit)
      begin
         case (sfr_req.addr)
            `DTC_ADDR_CLK_CTRL: clk_ctrl_next = sfr_req.wdata;
            `DTC_ADDR_MODE:     mode_next     = sfr_req.wdata;
            `DTC_ADDR_TMR0_LO:  t0_lo_next    = sfr_req.wdata;
            `DTC_ADDR_TMR0_HI:  t0_hi_next    = sfr_req.wdata;
            `DTC_ADDR_TMR1_LO:  t1_lo_next    = sfr_req.wdata;
            `DTC_ADDR_TMR1_HI:  t1_hi_next    = sfr_req.wdata;
            `DTC_ADDR_RUN_FLAG:
            begin
               run0_next  = sfr_req.wdata[`DTC_RF_RUN0];
               run1_next  = sfr_req.wdata[`DTC_RF_RUN1];
               flag0_next = sfr_req.wdata[`DTC_RF_FLAG0];
               flag1_next = sfr_req.wdata[`DTC_RF_FLAG1];
            end
            default:
            begin
               clk_ctrl_next = clk_ctrl_reg;
            end
         endcase
      end
      // vectoring clears, a same-cycle overflow still wins
      if (timer0_vector_ack)
         flag0_next = 1'b0;
      if (timer1_vector_ack)
         flag1_next = 1'b0;
      if (s0.ovf)
         flag0_next = 1'b1;
      if (t0_split ? hi0_ovf : s1.ovf)
         flag1_next = 1'b1;
      ovf0_next = s0.ovf;
      ovf1_next = s1.ovf;
   end

   // read data
   always_comb
   begin
      rdata_next = rdata_reg;
      if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            `DTC_ADDR_CLK_CTRL: rdata_next = clk_ctrl_reg;
            `DTC_ADDR_MODE:     rdata_next = mode_reg;
            `DTC_ADDR_TMR0_LO:  rdata_next = t0_lo_reg;
            `DTC_ADDR_TMR0_HI:  rdata_next = t0_hi_reg;
            `DTC_ADDR_TMR1_LO:  rdata_next = t1_lo_reg;
            `DTC_ADDR_TMR1_HI:  rdata_next = t1_hi_reg;
            `DTC_ADDR_RUN_FLAG: rdata_next = {flag1_reg, run1_reg, flag0_reg, run0_reg, 4'h0};
            default:            rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         clk_ctrl_reg <= `DTC_RST_CLK_CTRL;
         mode_reg     <= `DTC_RST_MODE;
         run0_reg     <= 1'b0;
         run1_reg     <= 1'b0;
         flag0_reg    <= 1'b0;
         flag1_reg    <= 1'b0;
         t0_lo_reg    <= `DTC_RST_COUNT;
         t0_hi_reg    <= `DTC_RST_COUNT;
         t1_lo_reg    <= `DTC_RST_COUNT;
         t1_hi_reg    <= `DTC_RST_COUNT;
         ovf0_reg     <= 1'b0;
         ovf1_reg     <= 1'b0;
         rdata_reg    <= 8'h00;
      end
      else
      begin
         clk_ctrl_reg <= clk_ctrl_next;
         mode_reg     <= mode_next;
         run0_reg     <= run0_next;
         run1_reg     <= run1_next;
         flag0_reg    <= flag0_next;
         flag1_reg    <= flag1_next;
         t0_lo_reg    <= t0_lo_next;
         t0_hi_reg    <= t0_hi_next;
         t1_lo_reg    <= t1_lo_next;
         t1_hi_reg    <= t1_hi_next;
         ovf0_reg     <= ovf0_next;
         ovf1_reg     <= ovf1_next;
         rdata_reg    <= rdata_next;
      end
   end

   assign sfr_rdata             = rdata_reg;
   assign timer0_irq            = flag0_reg & timer0_irq_enable;
   assign timer1_irq            = flag1_reg & timer1_irq_enable;
   assign timer0_overflow_pulse = ovf0_reg;
   assign timer1_overflow_pulse = ovf1_reg;
   assign timer_clock_control   = clk_ctrl_reg;
endmodule
`default_nettype wire

//--- dv/dtc_pin_model.sv
// Purpose: drives event, gate and external clock pins of the timer pair
// Assumes: called from the bench; changes at the falling clock edge
// Notes:   event and clock levels are held at least two system clocks
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model
(
   // clock
   input  wire logic clock,
   // pins
   output logic      event_pin_a,
   output logic      event_pin_b,
   output logic      gate_input_a,
   output logic      gate_input_b,
   output logic      ext_clock_in
);
   initial
   begin
      event_pin_a = 1'b1;
      event_pin_b = 1'b1;
      gate_input_a = 1'b0;
      gate_input_b = 1'b0;
      ext_clock_in = 1'b0;
   end
   task automatic set_gate_a(input logic v);
      @(negedge clock);
      gate_input_a = v;
   endtask
   task automatic pulse_a(input int n);
      repeat (n)
      begin
         @(negedge clock);
         event_pin_a = 1'b0;
         repeat (2) @(negedge clock);
         event_pin_a = 1'b1;
         repeat (2) @(negedge clock);
      end
   endtask
   task automatic pulse_b(input int n);
      repeat (n)
      begin
         @(negedge clock);
         event_pin_b = 1'b0;
         repeat (2) @(negedge clock);
         event_pin_b = 1'b1;
         repeat (2) @(negedge clock);
      end
   endtask
   task automatic ext_burst(input int n);
      repeat (n)
      begin
         repeat (3) @(negedge clock);
         ext_clock_in = 1'b1;
         repeat (3) @(negedge clock);
         ext_clock_in = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

//--- dv/dtc_timer_pair_checker.sv
// Purpose: port-level assertions for the timer pair
// Assumes: bound to dtc_timer_pair
// Notes:   flags are seen only through the interrupt outputs
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_timer_pair_checker
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // register access
   input  wire dtc_pkg::dtc_sfr_req_t sfr_req,
   input  wire logic [7:0]            sfr_rdata,
   input  wire logic [7:0]            timer_clock_control,
   // interrupts and overflow
   input  wire logic                  timer0_irq_enable,
   input  wire logic                  timer1_irq_enable,
   input  wire logic                  timer0_irq,
   input  wire logic                  timer1_irq,
   input  wire logic                  timer0_overflow_pulse,
   input  wire logic                  timer1_overflow_pulse
);
   import dtc_pkg::*;
   logic ck_wr;
   logic ck_rd;
   logic bad_rd;
   assign ck_wr = sfr_req.wr && sfr_req.addr == `DTC_ADDR_CLK_CTRL;
   assign ck_rd = sfr_req.rd && sfr_req.addr == `DTC_ADDR_CLK_CTRL;
   assign bad_rd = sfr_req.rd && (sfr_req.addr < `DTC_ADDR_RUN_FLAG || sfr_req.addr > `DTC_ADDR_CLK_CTRL);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_clkctrl_write: assert property (ck_wr |=> timer_clock_control == $past(sfr_req.wdata))
      else $error("clock control not written");
   a_clkctrl_hold: assert property (!ck_wr |=> $stable(timer_clock_control))
      else $error("clock control changed without write");
   a_clkctrl_read: assert property (ck_rd |=> sfr_rdata == $past(timer_clock_control))
      else $error("clock control read wrong");
   a_unmapped_read: assert property (bad_rd |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved without read");
   a_irq0_enable: assert property (timer0_irq |-> timer0_irq_enable)
      else $error("timer0 irq while disabled");
   a_irq1_enable: assert property (timer1_irq |-> timer1_irq_enable)
      else $error("timer1 irq while disabled");
   a_ovf0_flag: assert property (timer0_overflow_pulse && timer0_irq_enable |-> timer0_irq)
      else $error("timer0 overflow without flag");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> timer_clock_control == 8'h00 && !timer0_irq && !timer1_irq)
      else $error("outputs not cleared by reset");
   c_ovf0: cover property (timer0_overflow_pulse);
   c_ovf1: cover property (timer1_overflow_pulse);
   c_irq_ack: cover property (timer0_irq ##1 !timer0_irq);
endmodule
bind dtc_timer_pair dtc_timer_pair_checker u_chk (.clock(clock), .rst(rst), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .timer_clock_control(timer_clock_control), .timer0_irq_enable(timer0_irq_enable),
   .timer1_irq_enable(timer1_irq_enable), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
   .timer0_overflow_pulse(timer0_overflow_pulse), .timer1_overflow_pulse(timer1_overflow_pulse));
`default_nettype wire

//--- dv/dtc_timer_pair_tb.sv
// Purpose: register-level tests of the timer pair
// Assumes: inputs change at the falling edge
// Notes:   prescaler counts checked within one tick
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_timer_pair_tb;
   import dtc_pkg::*;
   localparam logic [7:0] rf = `DTC_ADDR_RUN_FLAG;
   localparam logic [7:0] md = `DTC_ADDR_MODE;
   localparam logic [7:0] ck = `DTC_ADDR_CLK_CTRL;
   // t, mode, hi, lo, expected hi, expected lo, flags, low mask
   localparam logic [63:0] tbl [6] = '{64'h00_00_ff_1e_00_00_20_1f, 64'h00_01_ff_fe_00_00_20_ff,
      64'h00_02_40_fe_40_40_20_ff, 64'h01_10_12_34_12_36_00_ff, 64'h01_30_12_34_12_34_00_ff,
      64'h01_20_80_fe_80_80_80_ff};
   logic         clock, rst, ev_a, ev_b, gt_a, gt_b, xclk, pol_a, pol_b;
   logic         ie0, ie1, ack0, ack1, irq0, irq1, ovp0, ovp1, seen;
   dtc_sfr_req_t sfr_req;
   logic [7:0]   sfr_rdata, timer_clock_control, rd_val, lo_a, n;
   logic [63:0]  c;
   int           num_errors, checks, cycles, ovf0_seen;
   int           expd [4] = '{8, 24, 2, 8};
   dtc_timer_pair dut (.clock(clock), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .event_pin_a(ev_a), .event_pin_b(ev_b), .gate_input_a(gt_a), .gate_input_b(gt_b),
      .ext_clock_in(xclk), .gate_a_polarity(pol_a), .gate_b_polarity(pol_b), .timer0_irq_enable(ie0),
      .timer1_irq_enable(ie1), .timer0_vector_ack(ack0), .timer1_vector_ack(ack1), .timer0_irq(irq0),
      .timer1_irq(irq1), .timer0_overflow_pulse(ovp0), .timer1_overflow_pulse(ovp1),
      .timer_clock_control(timer_clock_control));
   dtc_pin_model pins (.clock(clock), .event_pin_a(ev_a), .event_pin_b(ev_b), .gate_input_a(gt_a),
      .gate_input_b(gt_b), .ext_clock_in(xclk));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      sfr_req.addr = a;
      sfr_req.wdata = d;
      sfr_req.wr = 1'b1;
      @(negedge clock);
      sfr_req.wr = 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a);
      @(negedge clock);
      sfr_req.addr = a;
      sfr_req.rd = 1'b1;
      @(negedge clock);
      sfr_req.rd = 1'b0;
      rd_val = sfr_rdata;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
      sfr_rd(a);
      chk(name, {8'h00, rd_val}, {8'h00, e});
   endtask
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(negedge clock)
      ovf0_seen += int'(ovp0);
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         num_errors++;
         end_sim();
      end
   end
   initial
   begin
      rst = 1'b1;
      sfr_req = '0;
      {pol_a, pol_b, ie0, ie1, ack0, ack1} = 6'h0c;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) rd_chk("reset", 8'h88 + 8'(i), 8'h00);
      sfr_wr(ck, 8'ha5);
      rd_chk("clk_ctrl", ck, 8'ha5);
      chk("clk_ctrl_port", {8'h00, timer_clock_control}, 16'h00a5);
      sfr_wr(rf, 8'h0f);
      rd_chk("rf_low", rf, 8'h00);
      rd_chk("unmapped", 8'h90, 8'h00);
      $display("test registers done");
      foreach (tbl[i])
      begin
         c = tbl[i];
         lo_a = c[56] ? `DTC_ADDR_TMR1_LO : `DTC_ADDR_TMR0_LO;
         sfr_wr(ck, 8'h0c);
         sfr_wr(md, c[55:48]);
         sfr_wr(lo_a + 8'h02, c[47:40]);
         sfr_wr(lo_a, c[39:32]);
         sfr_wr(rf, 8'h00);
         sfr_wr(rf, c[56] ? 8'h40 : 8'h10);
         sfr_wr(rf, 8'h00);
         rd_chk("flags", rf, c[15:8]);
         sfr_rd(lo_a);
         chk("count_lo", {8'h00, rd_val & c[7:0]}, {8'h00, c[23:16]});
         rd_chk("count_hi", lo_a + 8'h02, c[31:24]);
         chk("irq", {14'h0, irq1, irq0}, {14'h0, c[15], c[13]});
         @(negedge clock);
         ack0 = 1'b1;
         ack1 = 1'b1;
         @(negedge clock);
         ack0 = 1'b0;
         ack1 = 1'b0;
         chk("irq_ack", {14'h0, irq1, irq0}, 16'h0000);
      end
      chk("ovf0_pulses", 16'(ovf0_seen), 16'h0003);
      $display("test modes done");
      sfr_wr(md, 8'h01);
      for (int s = 0; s < 4; s++)
      begin
         sfr_wr(ck, 8'(s));
         sfr_wr(`DTC_ADDR_TMR0_LO, 8'h00);
         sfr_wr(`DTC_ADDR_TMR0_HI, 8'h00);
         sfr_wr(rf, 8'h10);
         if (s == 3)
            pins.ext_burst(64);
         else
            repeat (94) @(negedge clock);
         sfr_wr(rf, 8'h00);
         sfr_rd(`DTC_ADDR_TMR0_LO);
         chk("prescale", 16'(int'(rd_val) >= expd[s] - 1 && int'(rd_val) <= expd[s] + 1), 16'h0001);
      end
      $display("test prescaler done");
      sfr_wr(ck, 8'h00);
      sfr_wr(`DTC_ADDR_TMR0_LO, 8'h00);
      n = 8'h00;
      for (int g = 0; g < 5; g++)
      begin
         sfr_wr(md, g == 0 ? 8'h05 : 8'h0d);
         pins.set_gate_a(1'(5'b01100 >> g));
         pol_a = 1'((5'b00111 >> g) & 1);
         repeat (3) @(negedge clock);
         sfr_wr(rf, 8'h10);
         pins.pulse_a(3);
         repeat (4) @(negedge clock);
         sfr_wr(rf, 8'h00);
         n = n + 8'(((5'b10101 >> g) & 1) * 3);
         rd_chk("events", `DTC_ADDR_TMR0_LO, n);
      end
      sfr_wr(md, 8'hd0);
      sfr_wr(`DTC_ADDR_TMR1_LO, 8'h00);
      for (int g = 0; g < 2; g++)
      begin
         pol_b = 1'(g);
         repeat (3) @(negedge clock);
         sfr_wr(rf, 8'h40);
         pins.pulse_b(2);
         repeat (4) @(negedge clock);
         sfr_wr(rf, 8'h00);
         rd_chk("events_b", `DTC_ADDR_TMR1_LO, 8'h02);
      end
      $display("test events done");
      sfr_wr(ck, 8'h0c);
      sfr_wr(md, 8'h13);
      sfr_wr(`DTC_ADDR_TMR0_LO, 8'hfe);
      sfr_wr(`DTC_ADDR_TMR0_HI, 8'hfe);
      sfr_wr(rf, 8'h00);
      sfr_wr(rf, 8'h50);
      sfr_wr(rf, 8'h00);
      rd_chk("split_flags", rf, 8'ha0);
      rd_chk("split_lo", `DTC_ADDR_TMR0_LO, 8'h00);
      rd_chk("split_hi", `DTC_ADDR_TMR0_HI, 8'h00);
      sfr_wr(rf, 8'h00);
      sfr_wr(`DTC_ADDR_TMR1_HI, 8'hff);
      sfr_wr(`DTC_ADDR_TMR1_LO, 8'hff);
      seen = 1'b0;
      repeat (6)
      begin
         @(negedge clock);
         seen = seen | ovp1;
      end
      chk("t1_pulse", {15'h0, seen}, 16'h0001);
      rd_chk("no_flag1", rf, 8'h00);
      sfr_wr(md, 8'h33);
      sfr_rd(`DTC_ADDR_TMR1_LO);
      n = rd_val;
      repeat (5) @(negedge clock);
      rd_chk("t1_halt", `DTC_ADDR_TMR1_LO, n);
      $display("test split done");
      end_sim();
   end
endmodule
`default_nettype wire
